// ===== design/asd_pkg.sv
package asd_pkg;

  // ----------------------------------------------------------------
  // Address space geometry
  // ----------------------------------------------------------------
  localparam int unsigned REG_SPACE_BYTES  = 4096;
  localparam int unsigned PROG_SPACE_BYTES = 65536;
  localparam int unsigned RAM_MAX_BYTES    = 256;
  localparam int unsigned FLASH_MIN_BYTES  = 1024;
  localparam int unsigned FLASH_MAX_BYTES  = 12288;
  localparam int unsigned FLASH_DEF_BYTES  = 8192;

  localparam logic [11:0] RAM_BASE      = 12'h000;
  localparam logic [11:0] CTRL_BASE     = 12'hf00;
  localparam logic [11:0] CTRL_LAST     = 12'hfff;

  // Fixed low program memory layout
  localparam logic [15:0] OPTION_BYTES_BASE = 16'h0000;
  localparam logic [15:0] RESET_VECTOR_BASE = 16'h0002;
  localparam logic [15:0] INT_VECTORS_BASE  = 16'h0004;
  localparam logic [15:0] INT_VECTORS_LAST  = 16'h003d;
  localparam logic [15:0] CODE_BASE         = 16'h003e;

  // Information area overlay
  localparam logic [15:0] INFO_BASE         = 16'hfe00;
  localparam logic [15:0] INFO_LAST         = 16'hfe7f;
  localparam logic [15:0] INFO_OPTIONS_BASE = 16'hfe00;
  localparam logic [15:0] INFO_PARTNUM_BASE = 16'hfe40;
  localparam logic [15:0] INFO_PARTNUM_LAST = 16'hfe53;
  localparam logic [15:0] INFO_CALIB_BASE   = 16'hfe60;
  localparam int unsigned INFO_BYTES        = 128;
  localparam int unsigned INFO_EN_BIT       = 7;

  // Value returned for unimplemented program memory
  localparam logic [7:0]  PROG_EMPTY_BYTE   = 8'hff;

  // ----------------------------------------------------------------
  // Control register map
  // ----------------------------------------------------------------
  localparam int unsigned GRP_TIMER0     = 0;
  localparam int unsigned GRP_TIMER1     = 1;
  localparam int unsigned GRP_CONVERTER  = 2;
  localparam int unsigned GRP_POWER      = 3;
  localparam int unsigned GRP_LAMP       = 4;
  localparam int unsigned GRP_OSC        = 5;
  localparam int unsigned GRP_COMPARATOR = 6;
  localparam int unsigned GRP_INTCTL     = 7;
  localparam int unsigned GRP_PORTA      = 8;
  localparam int unsigned GRP_COUNT      = 9;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  rstVal;
    logic        readOnly;
    logic [3:0]  group;
  } asd_ctrl_entry_t;

  localparam int unsigned CTRL_COUNT = 41;

  localparam asd_ctrl_entry_t CTRL_MAP [CTRL_COUNT] = '{
    '{12'hf00, 8'h00, 1'b0, 4'h0}, // timer0_count_high
    '{12'hf01, 8'h01, 1'b0, 4'h0}, // timer0_count_low
    '{12'hf02, 8'hff, 1'b0, 4'h0}, // timer0_reload_high
    '{12'hf03, 8'hff, 1'b0, 4'h0}, // timer0_reload_low
    '{12'hf04, 8'h00, 1'b0, 4'h0}, // timer0_pulse_width_high
    '{12'hf05, 8'h00, 1'b0, 4'h0}, // timer0_pulse_width_low
    '{12'hf06, 8'h00, 1'b0, 4'h0}, // timer0_control_a
    '{12'hf07, 8'h00, 1'b0, 4'h0}, // timer0_control_b
    '{12'hf08, 8'h00, 1'b0, 4'h1}, // timer1_count_high
    '{12'hf09, 8'h01, 1'b0, 4'h1}, // timer1_count_low
    '{12'hf0a, 8'hff, 1'b0, 4'h1}, // timer1_reload_high
    '{12'hf0b, 8'hff, 1'b0, 4'h1}, // timer1_reload_low
    '{12'hf0c, 8'h00, 1'b0, 4'h1}, // timer1_pulse_width_high
    '{12'hf0d, 8'h00, 1'b0, 4'h1}, // timer1_pulse_width_low
    '{12'hf0e, 8'h00, 1'b0, 4'h1}, // timer1_control_a
    '{12'hf0f, 8'h00, 1'b0, 4'h1}, // timer1_control_b
    '{12'hf70, 8'h00, 1'b0, 4'h2}, // converter_control_a
    '{12'hf72, 8'h00, 1'b1, 4'h2}, // converter_result_high
    '{12'hf73, 8'h00, 1'b1, 4'h2}, // converter_result_low
    '{12'hf75, 8'h3f, 1'b0, 4'h2}, // converter_sample_time
    '{12'hf76, 8'h00, 1'b0, 4'h2}, // converter_clock_divider
    '{12'hf80, 8'h88, 1'b0, 4'h3}, // power_control_a
    '{12'hf82, 8'h00, 1'b0, 4'h4}, // lamp_drive_enable
    '{12'hf83, 8'h00, 1'b0, 4'h4}, // lamp_drive_level_high
    '{12'hf84, 8'h00, 1'b0, 4'h4}, // lamp_drive_level_low
    '{12'hf86, 8'ha0, 1'b0, 4'h5}, // oscillator_control
    '{12'hf90, 8'h14, 1'b0, 4'h6}, // comparator_zero_control
    '{12'hfc0, 8'h00, 1'b0, 4'h7}, // int_request_group_a
    '{12'hfc1, 8'h00, 1'b0, 4'h7}, // int_enable_hi_group_a
    '{12'hfc2, 8'h00, 1'b0, 4'h7}, // int_enable_lo_group_a
    '{12'hfc3, 8'h00, 1'b0, 4'h7}, // int_request_group_b
    '{12'hfc4, 8'h00, 1'b0, 4'h7}, // int_enable_hi_group_b
    '{12'hfc5, 8'h00, 1'b0, 4'h7}, // int_enable_lo_group_b
    '{12'hfc6, 8'h00, 1'b0, 4'h7}, // int_request_group_c
    '{12'hfc7, 8'h00, 1'b0, 4'h7}, // int_enable_hi_group_c
    '{12'hfc8, 8'h00, 1'b0, 4'h7}, // int_enable_lo_group_c
    '{12'hfcd, 8'h00, 1'b0, 4'h7}, // int_edge_polarity
    '{12'hfce, 8'h00, 1'b0, 4'h7}, // int_shared_source_select
    '{12'hfcf, 8'h00, 1'b0, 4'h7}, // int_global_control
    '{12'hfd0, 8'h00, 1'b0, 4'h8}, // port_a_subregister_index
    '{12'hfd1, 8'h00, 1'b0, 4'h8}  // port_a_subregister_value
  };

  // Program-side target of a registered access
  typedef enum logic [1:0] {
    PT_NONE,
    PT_FLASH,
    PT_INFO,
    PT_CONST
  } asd_prog_target_t;

endpackage

// ===== design/asd_decoder.sv
`timescale 1ns/1ns

// Contract
// R01: Register space has 4096 byte locations, general-purpose and control sections.
// R02: Addresses F00H to FFFH form the control-register section.
// R03: Reserved control addresses read back an undefined value.
// R04: Software should not write reserved control addresses.
// R05: RAM begins at 000H and holds at most 256 bytes.
// R06: Between RAM top and control section reads are undefined, writes ignored.
// R07: Program space spans 64 KB of byte addresses.
// R08: Flash fills the bottom, 1 KB to 12 KB; largest map ends 2FFF.
// R09: Program reads beyond implemented flash return FFH.
// R10: Program writes to unimplemented addresses change nothing.
// R11: Option bytes 0000-0001, reset vector 0002-0003, interrupt vectors 0004-003D.
// R12: Data-memory space is not implemented and never decoded.
// R13: Information area reachable only while page-select bit 7 is one.
// R14: Enabled information area overlays FE00H to FE7FH.
// R15: Overlay reads come from the information area; it takes no writes.
// R16: Info area: options FE00-FE3F, part number FE40-FE53, calibration FE60-FE7F.
// R17: Control registers of absent peripherals behave as reserved.
// R18: Each access raises exactly one target select and is decoded in one cycle.
module asd_decoder #(
  parameter int unsigned RAM_BYTES      = asd_pkg::RAM_MAX_BYTES,
  parameter int unsigned FLASH_BYTES    = asd_pkg::FLASH_DEF_BYTES,
  parameter logic [8:0]  PERIPH_PRESENT = 9'h1ff
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register file access from the core
  input  wire logic [11:0] regAddr,
  input  wire logic        regRdReq,
  input  wire logic        regWrReq,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData,
  output logic             regRdValid,
  output logic             regSelRam,
  output logic             regSelCtrl,
  output logic             regSelUndef,
  output logic             ctrlWrPulse,
  output logic [5:0]       ctrlWrIndex,
  output logic [7:0]       ctrlWrValue,
  // Program memory access from the core
  input  wire logic [15:0] progAddr,
  input  wire logic        progRdReq,
  input  wire logic        progWrReq,
  input  wire logic [7:0]  progWrData,
  input  wire logic [7:0]  pageSelect,
  input  wire logic [7:0]  flashRdData,
  input  wire logic [7:0]  infoRdData,
  output logic [15:0]      memAddr,
  output logic             flashRdEn,
  output logic             flashWrEn,
  output logic [7:0]       flashWrData,
  output logic             infoRdEn,
  output logic             progSelFlash,
  output logic             progSelInfo,
  output logic             progSelConst,
  output logic [7:0]       progRdData,
  output logic             progRdValid
);
  import asd_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RAM_BYTES < 1 || RAM_BYTES > RAM_MAX_BYTES) begin : gRamChk
    $error("RAM_BYTES out of range");
  end
  if (FLASH_BYTES < FLASH_MIN_BYTES || FLASH_BYTES > FLASH_MAX_BYTES) begin : gFlashChk
    $error("FLASH_BYTES out of range");
  end
  if (FLASH_BYTES > int'(INFO_BASE)) begin : gOverlapChk
    $error("flash may not reach the information area");
  end

  localparam logic [11:0] RAM_TOP   = 12'(RAM_BYTES);
  localparam logic [16:0] FLASH_TOP = 17'(FLASH_BYTES);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] ramMem [RAM_BYTES];
  logic [7:0] ctrlStore_reg [CTRL_COUNT];

  // ----------------------------------------------------------------
  // Register-side decode
  // ----------------------------------------------------------------
  logic       regReq;
  logic       hitRam;
  logic       hitCtrlSpace;
  logic       hitCtrl;
  logic       hitCtrlWritable;
  logic [5:0] hitIndex;
  logic [7:0] ctrlRdValue;

  assign regReq       = regRdReq | regWrReq;
  // 12-bit address covers exactly the 4096-byte space
  assign hitRam       = (regAddr - RAM_BASE) < RAM_TOP;              // R01 R05
  assign hitCtrlSpace = (regAddr >= CTRL_BASE) && (regAddr <= CTRL_LAST); // R02

  // Table lookup; absent peripherals fall back to reserved
  always_comb begin
    hitCtrl         = 1'b0;
    hitCtrlWritable = 1'b0;
    hitIndex        = 6'h00;
    ctrlRdValue     = 8'h00;
    for (int i = 0; i < CTRL_COUNT; i++) begin
      if (hitCtrlSpace && regAddr == CTRL_MAP[i].addr &&
          PERIPH_PRESENT[CTRL_MAP[i].group]) begin // R17
        hitCtrl         = 1'b1;
        hitCtrlWritable = ~CTRL_MAP[i].readOnly;
        hitIndex        = 6'(i);
        ctrlRdValue     = ctrlStore_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // General-purpose RAM
  // ----------------------------------------------------------------
  // Writes only land inside the implemented RAM
  always_ff @(posedge sys_clk) begin
    if (regWrReq && hitRam) begin // R05 R06
      ramMem[regAddr[7:0] % RAM_BYTES] <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // Control register storage
  // ----------------------------------------------------------------
  // Reserved and read-only locations never store
  for (genvar g = 0; g < CTRL_COUNT; g++) begin : gCtrl
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrlStore_reg[g] <= CTRL_MAP[g].rstVal;
      end else if (regWrReq && hitCtrl && hitCtrlWritable && hitIndex == 6'(g)) begin // R04
        ctrlStore_reg[g] <= regWrData;
      end
    end
  end

  // Write notice to the owning peripheral
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlWrPulse <= 1'b0;
      ctrlWrIndex <= 6'h00;
      ctrlWrValue <= 8'h00;
    end else begin
      ctrlWrPulse <= regWrReq && hitCtrl && hitCtrlWritable;
      if (regWrReq && hitCtrl && hitCtrlWritable) begin
        ctrlWrIndex <= hitIndex;
        ctrlWrValue <= regWrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register-side selects and read data
  // ----------------------------------------------------------------
  // One select per access, none when idle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regSelRam   <= 1'b0;
      regSelCtrl  <= 1'b0;
      regSelUndef <= 1'b0;
    end else begin
      regSelRam   <= regReq && hitRam;                 // R18
      regSelCtrl  <= regReq && hitCtrl;                // R18
      regSelUndef <= regReq && !hitRam && !hitCtrl;    // R18 R06 R03
    end
  end

  // Undefined reads leave the previous bus value standing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdReq;
      if (regRdReq && hitRam) begin
        regRdData <= ramMem[regAddr[7:0] % RAM_BYTES];
      end else if (regRdReq && hitCtrl) begin
        regRdData <= ctrlRdValue;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program-side decode
  // ----------------------------------------------------------------
  logic             progReq;
  logic             rdConst_reg;
  logic             infoEnabled;
  logic             inInfo;
  logic             inFlash;
  asd_prog_target_t progTarget;

  assign progReq     = progRdReq | progWrReq;
  assign infoEnabled = pageSelect[INFO_EN_BIT];                       // R13
  assign inInfo      = (progAddr >= INFO_BASE) && (progAddr <= INFO_LAST); // R14
  // Option bytes, vectors and code all sit in flash from 0000 upward
  assign inFlash     = {1'b0, progAddr} < FLASH_TOP;                  // R07 R08 R11

  // Overlay takes priority over the normal map
  always_comb begin
    progTarget = PT_NONE;
    if (progReq) begin
      if (infoEnabled && inInfo) begin
        progTarget = PT_INFO;  // R14 R15
      end else if (inFlash) begin
        progTarget = PT_FLASH;
      end else begin
        progTarget = PT_CONST; // R09
      end
    end
  end

  // Stage 1: address, strobes and selects to the memories
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memAddr      <= 16'h0000;
      flashRdEn    <= 1'b0;
      flashWrEn    <= 1'b0;
      flashWrData  <= 8'h00;
      infoRdEn     <= 1'b0;
      progSelFlash <= 1'b0;
      progSelInfo  <= 1'b0;
      progSelConst <= 1'b0;
    end else begin
      if (progReq) begin
        memAddr <= progAddr;
      end
      flashRdEn    <= progRdReq && progTarget == PT_FLASH;
      flashWrEn    <= progWrReq && progTarget == PT_FLASH;   // R10 R15
      infoRdEn     <= progRdReq && progTarget == PT_INFO;    // R15 R16
      progSelFlash <= progTarget == PT_FLASH;                // R18
      progSelInfo  <= progTarget == PT_INFO;                 // R18
      progSelConst <= progTarget == PT_CONST;                // R18 R10
      if (progWrReq && progTarget == PT_FLASH) begin
        flashWrData <= progWrData;
      end
    end
  end

  // Stage 2: read data captured from the selected source
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      progRdData  <= 8'h00;
      progRdValid <= 1'b0;
    end else begin
      progRdValid <= flashRdEn | infoRdEn | (progSelConst && !flashWrEn && rdConst_reg);
      if (infoRdEn) begin
        progRdData <= infoRdData;          // R15
      end else if (flashRdEn) begin
        progRdData <= flashRdData;
      end else if (progSelConst && rdConst_reg) begin
        progRdData <= PROG_EMPTY_BYTE;     // R09
      end
    end
  end

  // Remembers that a constant-path access was a read
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdConst_reg <= 1'b0;
    end else begin
      rdConst_reg <= progRdReq && progTarget == PT_CONST;
    end
  end

  // No data-memory port exists: that space is never decoded (R12)

endmodule

// ===== bench/asd_decoder_assertions.sv
`timescale 1ns/1ns
module asd_decoder_assertions #(
  parameter int unsigned RAM_BYTES   = 256,
  parameter int unsigned FLASH_BYTES = 8192
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] regAddr,
  input wire logic        regRdReq,
  input wire logic        regWrReq,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdValid,
  input wire logic        regSelRam,
  input wire logic        regSelCtrl,
  input wire logic        regSelUndef,
  input wire logic        ctrlWrPulse,
  input wire logic [15:0] progAddr,
  input wire logic        progRdReq,
  input wire logic        progWrReq,
  input wire logic [7:0]  pageSelect,
  input wire logic [7:0]  infoRdData,
  input wire logic [15:0] memAddr,
  input wire logic        flashRdEn,
  input wire logic        flashWrEn,
  input wire logic        infoRdEn,
  input wire logic        progSelFlash,
  input wire logic        progSelInfo,
  input wire logic        progSelConst,
  input wire logic [7:0]  progRdData,
  input wire logic        progRdValid
);
  logic regReq;
  logic inGap;
  logic inInfo;
  // Request qualifiers
  assign regReq = regRdReq | regWrReq;
  assign inGap  = (regAddr >= RAM_BYTES) && (regAddr < 12'hf00);
  assign inInfo = (progAddr >= 16'hfe00) && (progAddr <= 16'hfe7f) && pageSelect[7];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Register side
  // ----
  a_reg_latency: assert property (regRdReq |=> regRdValid)
    else $error("register read got no answer");
  a_reg_onehot: assert property (regReq |=> $onehot({regSelRam, regSelCtrl, regSelUndef}))
    else $error("register select not one-hot");
  a_ram_select: assert property (regReq && regAddr < RAM_BYTES |=> regSelRam)
    else $error("low address missed RAM");
  a_gap_undef: assert property (regReq && inGap |=> regSelUndef && !ctrlWrPulse)
    else $error("gap access not undefined");
  a_ctrl_section: assert property (regReq && regAddr < 12'hf00 |=> !regSelCtrl)
    else $error("control select below control section");
  a_undef_holds: assert property (regSelUndef && regRdValid |-> $stable(regRdData))
    else $error("undefined read changed data");
  // ----
  // Program side
  // ----
  a_prog_onehot: assert property ((progRdReq || progWrReq) |=>
    $onehot({progSelFlash, progSelInfo, progSelConst}))
    else $error("program select not one-hot");
  a_flash_path: assert property (progRdReq && !inInfo && progAddr < FLASH_BYTES |=>
    flashRdEn && memAddr == $past(progAddr) ##1 progRdValid)
    else $error("flash read path wrong");
  a_empty_ff: assert property (progRdReq && !inInfo && progAddr >= FLASH_BYTES |=>
    progSelConst ##1 progRdValid && progRdData == 8'hff)
    else $error("empty program read not ff");
  a_info_read: assert property (progRdReq && inInfo |=>
    progSelInfo && infoRdEn ##1 progRdData == $past(infoRdData))
    else $error("overlay read wrong");
  a_no_prog_write: assert property (progWrReq && (inInfo || progAddr >= FLASH_BYTES)
    |=> !flashWrEn)
    else $error("refused program write forwarded");
  c_info_read: cover property (progRdReq && inInfo);
  c_gap_access: cover property (regReq && inGap);
  c_ctrl_write: cover property (ctrlWrPulse);
endmodule

// ===== bench/asd_mem_model.sv
`timescale 1ns/1ns
module asd_mem_model (
  input  wire logic [15:0] memAddr,
  input  wire logic        flashRdEn,
  input  wire logic        infoRdEn,
  output logic [7:0]       flashRdData,
  output logic [7:0]       infoRdData
);
  logic [7:0] flashByte;
  logic [7:0] infoByte;
  // Contents are address patterns
  assign flashByte = memAddr[7:0] ^ memAddr[15:8];
  assign infoByte  = memAddr[7:0] + 8'h01;
  // Unselected array shows the inverse, never a stale byte
  assign flashRdData = flashRdEn ? flashByte : ~flashByte;
  assign infoRdData  = infoRdEn ? infoByte : ~infoByte;
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  import asd_pkg::*;
  typedef struct packed {logic [15:0] addr; logic [7:0] page; logic [2:0] sel;} asd_row_t;
  localparam asd_row_t ROWS [10] = '{
    '{16'h0000, 8'h00, 3'b100}, '{16'h0003, 8'h00, 3'b100},
    '{16'h003d, 8'h80, 3'b100}, '{16'h1fff, 8'h00, 3'b100},
    '{16'h2000, 8'h00, 3'b001}, '{16'hfe00, 8'h80, 3'b010},
    '{16'hfe7f, 8'h80, 3'b010}, '{16'hfe80, 8'h80, 3'b001},
    '{16'hfe40, 8'h7f, 3'b001}, '{16'hffff, 8'h00, 3'b001}};
  logic        sys_clk;
  logic        sys_rst = 1'b1;
  logic        regRdReq = 1'b0, regWrReq = 1'b0, progRdReq = 1'b0, progWrReq = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [15:0] progAddr = 16'h0000, memAddr;
  logic [7:0]  regWrData = 8'h00, progWrData = 8'h00, pageSelect = 8'h00;
  logic [7:0]  regRdData, ctrlWrValue, flashWrData, progRdData, flashRdData, infoRdData;
  logic [5:0]  ctrlWrIndex;
  logic        regRdValid, regSelRam, regSelCtrl, regSelUndef, ctrlWrPulse, wrSeen;
  logic        flashRdEn, flashWrEn, infoRdEn, progSelFlash, progSelInfo, progSelConst;
  logic        progRdValid;
  logic [2:0]  selSeen;
  int          n_errors = 0;
  int          checked = 0;
  asd_decoder #(.RAM_BYTES(128), .PERIPH_PRESENT(9'h1fe)) asd_decoder_i (.sys_clk, .sys_rst,
    .regAddr, .regRdReq, .regWrReq, .regWrData, .regRdData, .regRdValid, .regSelRam,
    .regSelCtrl, .regSelUndef, .ctrlWrPulse, .ctrlWrIndex, .ctrlWrValue, .progAddr,
    .progRdReq, .progWrReq, .progWrData, .pageSelect, .flashRdData, .infoRdData, .memAddr,
    .flashRdEn, .flashWrEn, .flashWrData, .infoRdEn, .progSelFlash, .progSelInfo,
    .progSelConst, .progRdData, .progRdValid);
  asd_mem_model asd_mem_model_i (.memAddr, .flashRdEn, .infoRdEn, .flashRdData, .infoRdData);
  // ----
  // Helpers
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One register access; returns in the answer cycle
  task automatic reg_op(input logic [11:0] a, input logic rd, input logic wr,
                        input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdReq <= rd;
    regWrReq <= wr;
    regWrData <= d;
    @(posedge sys_clk);
    regRdReq <= 1'b0;
    regWrReq <= 1'b0;
    #1;
  endtask
  // One program access; returns in the data cycle
  task automatic prog_op(input logic [15:0] a, input logic [7:0] p, input logic rd,
                         input logic wr);
    @(posedge sys_clk);
    progAddr <= a;
    pageSelect <= p;
    progRdReq <= rd;
    progWrReq <= wr;
    progWrData <= 8'ha5;
    @(posedge sys_clk);
    progRdReq <= 1'b0;
    progWrReq <= 1'b0;
    #1;
    selSeen = {progSelFlash, progSelInfo, progSelConst};
    wrSeen = flashWrEn;
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [7:0] exp_byte(asd_row_t r);
    if (r.sel == 3'b100) return r.addr[7:0] ^ r.addr[15:8];
    if (r.sel == 3'b010) return r.addr[7:0] + 8'h01;
    return 8'hff;
  endfunction
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      prog_op(ROWS[i].addr, ROWS[i].page, 1'b1, 1'b0);
      check(16'({selSeen, progRdValid, progRdData}),
            16'({ROWS[i].sel, 1'b1, exp_byte(ROWS[i])}));
    end
    for (int i = 0; i < CTRL_COUNT; i++) begin
      reg_op(CTRL_MAP[i].addr, 1'b1, 1'b0, 8'h00);
      if (CTRL_MAP[i].group == 4'h0) check(16'(regSelUndef), 16'h0001);
      else check(16'({regSelCtrl, regRdData}), 16'({1'b1, CTRL_MAP[i].rstVal}));
    end
    // RAM top and the gap just above it
    reg_op(12'h07f, 1'b0, 1'b1, 8'hc3);
    reg_op(12'h07f, 1'b1, 1'b0, 8'h00);
    check(16'({regRdValid, regSelRam, regRdData}), 16'h03c3);
    reg_op(12'h080, 1'b0, 1'b1, 8'h11);
    check(16'({regSelUndef, ctrlWrPulse}), 16'h0002);
    reg_op(12'heff, 1'b1, 1'b0, 8'h00);
    check(16'({regRdValid, regSelUndef, regRdData}), 16'h03c3);
    // Reserved slot is only read and holds; read-only result stores nothing
    reg_op(12'hf71, 1'b1, 1'b0, 8'h00);
    check(16'({regSelUndef, regRdValid, regRdData}), 16'h03c3);
    reg_op(12'hf72, 1'b0, 1'b1, 8'h55);
    check(16'({regSelCtrl, ctrlWrPulse}), 16'h0002);
    reg_op(12'hf72, 1'b1, 1'b0, 8'h00);
    check(16'(regRdData), 16'h0000);
    // Oscillator control store, then reset mid-run restores it
    reg_op(12'hf86, 1'b0, 1'b1, 8'h5a);
    check(16'({ctrlWrPulse, ctrlWrIndex, ctrlWrValue}), 16'h595a);
    reg_op(12'hf86, 1'b1, 1'b0, 8'h00);
    check(16'(regRdData), 16'h005a);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(16'({regRdData, ctrlWrValue}), 16'h0000);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    reg_op(12'hf86, 1'b1, 1'b0, 8'h00);
    check(16'(regRdData), 16'h00a0);
    // Program writes: forwarded in flash, dropped beyond it and in the overlay
    prog_op(16'h0200, 8'h00, 1'b0, 1'b1);
    check(16'({wrSeen, progRdValid, flashWrData}), 16'h02a5);
    prog_op(16'h2000, 8'h00, 1'b0, 1'b1);
    check(16'({wrSeen, selSeen}), 16'h0001);
    prog_op(16'hfe10, 8'h80, 1'b0, 1'b1);
    check(16'({wrSeen, selSeen}), 16'h0002);
    test_done();
  end
endmodule
bind asd_decoder asd_decoder_assertions #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES))
  asd_decoder_assertions_i (.sys_clk, .sys_rst, .regAddr, .regRdReq, .regWrReq, .regRdData,
  .regRdValid, .regSelRam, .regSelCtrl, .regSelUndef, .ctrlWrPulse, .progAddr, .progRdReq,
  .progWrReq, .pageSelect, .infoRdData, .memAddr, .flashRdEn, .flashWrEn, .infoRdEn,
  .progSelFlash, .progSelInfo, .progSelConst, .progRdData, .progRdValid);
